//--- rtl/sbe_pkg.sv
package sbe_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CONV_MAX_NS = 5000;
  localparam int unsigned CONV_CYC = CONV_MAX_NS * CLK_MHZ / 1000;
  localparam int unsigned BOOT_MAX_NS = 150000;
  localparam int unsigned BOOT_MAX_CYC = BOOT_MAX_NS * CLK_MHZ / 1000;
  localparam int unsigned TICK_NS = 5000;
  localparam int unsigned TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  localparam int unsigned BOOT_BASE_NS = 480000;
  localparam int unsigned BOOT_BASE_TICKS = BOOT_BASE_NS / TICK_NS;
  localparam int NCH = 6;
  localparam int ADC_W = 10;
  localparam int CFG_N = 64;
  localparam logic [7:0] A_RES_END = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_FLT = 8'h21;
  localparam logic [7:0] A_RNG0 = 8'h43;
  localparam logic [7:0] A_RNG1 = 8'h44;
  localparam logic [7:0] A_OV0 = 8'h48;
  localparam logic [7:0] A_UV0 = 8'h4e;
  localparam logic [7:0] A_OVEN = 8'h54;
  localparam logic [7:0] A_UVEN = 8'h55;
  localparam logic [7:0] A_LOGEN = 8'h56;
  localparam logic [7:0] A_GPM0 = 8'h58;
  localparam logic [7:0] A_RTO = 8'h5e;
  localparam logic [7:0] A_MODE = 8'h5f;
  localparam logic [7:0] A_ENCFG = 8'h73;
  localparam logic [7:0] A_BDLY = 8'h77;
  localparam logic [9:0] FLASH_CFG_BASE = 10'h240;
  localparam logic [9:0] FLASH_LOG_BASE = 10'h2c0;
  localparam int EN_SW = 0;
  localparam int EN_MARGIN = 2;
  localparam int EN_WDIND = 4;
  localparam logic [7:0] ENCFG_MASK = 8'h15;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int ST_LOCK = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_DROP = 2;
  localparam int MODE_LATCH = 0;
  localparam int MODE_RPOL = 1;
  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbe_acc_t;
  typedef struct packed {
    logic ack;
    logic refused;
    logic [7:0] rdata;
  } sbe_rsp_t;
  typedef enum logic [1:0] {
    GS_IDLE = 2'b00,
    GS_DELAY = 2'b01,
    GS_MON = 2'b10
  } sbe_gate_t;
endpackage

//--- rtl/sbe_boot_copy.sv
`timescale 1ns/1ns
`default_nettype none
module sbe_boot_copy #(
  parameter int N = sbe_pkg::CFG_N,
  parameter int unsigned MAX_CYC = sbe_pkg::BOOT_MAX_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Flash read, data one cycle after address
  output logic [9:0] flash_raddr,
  input wire logic [7:0] flash_rdata,
  // Register load
  output logic wr_en,
  output logic [5:0] wr_idx,
  output logic [7:0] wr_data,
  output logic done
);
  import sbe_pkg::*;
  logic [6:0] cnt;
  logic [15:0] age;
  logic vld;

  wire [6:0] next_cnt = cnt + {6'd0, cnt != 7'(N)};

  assign wr_en = vld && !done;
  assign wr_data = flash_rdata;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt <= '0;
      flash_raddr <= FLASH_CFG_BASE;
      age <= '0;
      vld <= 1'b0;
      wr_idx <= '0;
      done <= 1'b0;
    end else if (!done) begin
      vld <= cnt < 7'(N);
      wr_idx <= cnt[5:0];
      cnt <= next_cnt;
      flash_raddr <= FLASH_CFG_BASE + {3'b000, next_cnt};
      age <= age + 16'd1;
      // Hard stop keeps boot bounded even with a slow flash
      done <= (cnt == 7'(N)) || (age == 16'(MAX_CYC - 2));
    end
  end
endmodule
`default_nettype wire

//--- rtl/sbe_rail_scan.sv
`timescale 1ns/1ns
`default_nettype none
module sbe_rail_scan #(
  parameter int NCH = sbe_pkg::NCH,
  parameter int W = sbe_pkg::ADC_W,
  parameter int unsigned CONV_CYC = sbe_pkg::CONV_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [NCH-1:0] skip,
  // Converter
  output logic adc_start,
  output logic [2:0] adc_chan,
  input wire logic adc_done,
  input wire logic [W-1:0] adc_result,
  // Results
  output logic [NCH-1:0][W-1:0] res,
  output logic cmp_valid,
  output logic [2:0] cmp_chan
);
  logic busy;
  logic [9:0] tmo;
  logic [2:0] ch;
  wire [2:0] next_ch = (ch == 3'(NCH - 1)) ? 3'd0 : ch + 3'd1;

  assign adc_chan = ch;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ch <= '0;
      busy <= 1'b0;
      tmo <= '0;
      adc_start <= 1'b0;
      cmp_valid <= 1'b0;
      cmp_chan <= '0;
      res <= '0;
    end else begin
      adc_start <= 1'b0;
      cmp_valid <= 1'b0;
      if (!busy) begin
        if (run && !skip[ch]) begin
          busy <= 1'b1;
          adc_start <= 1'b1;
          tmo <= '0;
        end else if (run) begin
          ch <= next_ch;
        end
      end else if (adc_done || tmo == 10'(CONV_CYC - 1)) begin
        // A stuck converter costs one stop, not the whole scan
        busy <= 1'b0;
        ch <= next_ch;
        if (adc_done) begin
          res[ch] <= adc_result;
          cmp_valid <= 1'b1;
          cmp_chan <= ch;
        end
      end else begin
        tmo <= tmo + 10'd1;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/sbe_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module sbe_supervisor #(
  parameter int unsigned BOOT_MAX_CYC = sbe_pkg::BOOT_MAX_CYC,
  parameter int unsigned TICK_CYC = sbe_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Gate comparator and address strap
  input wire logic gate_cmp,
  input wire logic [1:0] address_select_pin,
  output logic [1:0] bus_addr_code,
  // Register access from the serial front end
  input wire sbe_pkg::sbe_acc_t acc,
  input wire logic page_cmd,
  input wire logic [1:0] page_sel,
  output sbe_pkg::sbe_rsp_t rsp,
  // Flash
  output logic [9:0] flash_raddr,
  input wire logic [7:0] flash_rdata,
  output logic flash_wr,
  output logic [9:0] flash_waddr,
  output logic [7:0] flash_wdata,
  // Converter
  output logic adc_start,
  output logic [2:0] adc_chan,
  input wire logic adc_done,
  input wire logic [9:0] adc_result,
  // Pins
  output logic reset_out,
  output logic [5:0] gpio_out,
  output logic [5:0] gpio_oe_n
);
  import sbe_pkg::*;

  function automatic logic in_cfg(input logic [7:0] a);
    return a[7:6] == 2'b01;
  endfunction

  logic [7:0] cfg [0:CFG_N-1];
  sbe_gate_t state;
  logic boot_done, bw_en, strap_done, tick, latched, drop, lock;
  logic gate_q, sw_q, log_busy;
  logic [5:0] bw_idx;
  logic [7:0] bw_data;
  logic [1:0] page;
  logic [8:0] tick_cnt;
  logic [20:0] dly_cnt;
  logic [7:0] rto_cnt;
  logic [2:0] log_i;
  logic [5:0] flt_act, flt_rec;
  logic [NCH-1:0][9:0] res;
  logic cmp_valid;
  logic [2:0] cmp_chan;

  sbe_boot_copy #(.N(CFG_N), .MAX_CYC(BOOT_MAX_CYC)) u_boot (
    .ref_clk(ref_clk),
    .reset(reset),
    .flash_raddr(flash_raddr),
    .flash_rdata(flash_rdata),
    .wr_en(bw_en),
    .wr_idx(bw_idx),
    .wr_data(bw_data),
    .done(boot_done)
  );

  // Range code 11 drops the channel from the scan
  wire [7:0] rng0 = cfg[A_RNG0[5:0]];
  wire [7:0] rng1 = cfg[A_RNG1[5:0]];
  wire [5:0] skip = {&rng1[3:2], &rng1[1:0], &rng0[7:6], &rng0[5:4], &rng0[3:2], &rng0[1:0]};

  sbe_rail_scan #(.NCH(NCH), .W(ADC_W), .CONV_CYC(CONV_CYC)) u_scan (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(state == GS_MON),
    .skip(skip),
    .adc_start(adc_start),
    .adc_chan(adc_chan),
    .adc_done(adc_done),
    .adc_result(adc_result),
    .res(res),
    .cmp_valid(cmp_valid),
    .cmp_chan(cmp_chan)
  );

  // Enable register fields
  wire [7:0] enc = cfg[A_ENCFG[5:0]];
  wire sw_en = enc[EN_SW];
  wire margin = enc[EN_MARGIN];
  wire [7:0] mode = cfg[A_MODE[5:0]];
  wire [7:0] bdly = cfg[A_BDLY[5:0]];
  wire gate_ok = boot_done && gate_cmp && sw_en;
  wire fall = (gate_q && !gate_cmp) || (sw_q && !sw_en);
  wire [20:0] dly_tgt = (21'(5'd16 + {1'b0, bdly[3:0]}) << bdly[7:4]) + 21'(BOOT_BASE_TICKS);

  // Host access decode
  wire acc_ok = acc.valid && boot_done && page == 2'b00;
  wire wr_hit = acc_ok && acc.wr;
  wire clr_drop = wr_hit && acc.addr == A_STAT && acc.wdata[ST_DROP];
  wire [5:0] clr_flt = (wr_hit && acc.addr == A_FLT) ? acc.wdata[5:0] : 6'd0;
  wire [2:0] ri = 3'(acc.addr[3:1]);
  wire [7:0] rd_res = acc.addr[0] ? {res[ri][1:0], 6'd0} : res[ri][9:2];
  wire [7:0] rd_data = (acc.addr < A_RES_END) ? rd_res :
                       (acc.addr == A_STAT) ? {5'd0, drop, latched, lock} :
                       (acc.addr == A_FLT) ? {2'd0, flt_rec} :
                       in_cfg(acc.addr) ? cfg[acc.addr[5:0]] : 8'h00;

  // Threshold compare on the 8 upper result bits
  wire [7:0] res_msb = res[cmp_chan][9:2];
  wire [7:0] ov_thr = cfg[6'(A_OV0[5:0] + {3'd0, cmp_chan})];
  wire [7:0] uv_thr = cfg[6'(A_UV0[5:0] + {3'd0, cmp_chan})];
  wire ov_en = cfg[A_OVEN[5:0]][cmp_chan];
  wire uv_en = cfg[A_UVEN[5:0]][cmp_chan];
  wire viol = ((res_msb > ov_thr) && ov_en) || ((res_msb < uv_thr) && uv_en);
  wire rec_ok = cmp_valid && state == GS_MON && !margin;
  wire [5:0] next_act = rec_ok ? ((flt_act & ~(6'd1 << cmp_chan)) | (6'(viol) << cmp_chan)) :
                        (state == GS_MON) ? flt_act : 6'd0;
  wire new_flt = |(next_act & ~flt_act);
  wire log_go = new_flt && |(next_act & cfg[A_LOGEN[5:0]][5:0]) && !lock && !log_busy;
  wire all_ok = state == GS_MON && flt_act == 6'd0 && !latched;
  wire rst_asrt = !all_ok || rto_cnt < cfg[A_RTO[5:0]];

  // Boot copy and host writes to the configuration bytes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < CFG_N; i++) begin
        cfg[i] <= CFG_RST;
      end
    end else if (bw_en) begin
      cfg[bw_idx] <= (bw_idx == A_ENCFG[5:0]) ? (bw_data & ENCFG_MASK) : bw_data;
    end else if (wr_hit && in_cfg(acc.addr)) begin
      cfg[acc.addr[5:0]] <= (acc.addr == A_ENCFG) ? (acc.wdata & ENCFG_MASK) : acc.wdata;
    end
  end

  // Strap caught once, right after power-on reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strap_done <= 1'b0;
      bus_addr_code <= 2'b00;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      bus_addr_code <= address_select_pin;
    end
  end

  // Register answers; page commands are ignored during boot
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      page <= 2'b00;
      rsp <= '0;
    end else begin
      if (page_cmd && boot_done && page_sel != 2'b11) begin
        page <= page_sel;
      end
      rsp.ack <= acc.valid;
      rsp.refused <= acc.valid && !acc_ok;
      rsp.rdata <= acc_ok ? rd_data : 8'h00;
    end
  end

  // Slow tick for boot delay and reset timeout
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 9'(TICK_CYC - 1);
      tick_cnt <= (tick_cnt == 9'(TICK_CYC - 1)) ? 9'd0 : tick_cnt + 9'd1;
    end
  end

  // Gate state machine
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= GS_IDLE;
      dly_cnt <= '0;
      gate_q <= 1'b0;
      sw_q <= 1'b0;
    end else begin
      gate_q <= gate_cmp;
      sw_q <= sw_en;
      unique case (state)
        GS_IDLE: begin
          dly_cnt <= '0;
          if (gate_ok) begin
            state <= GS_DELAY;
          end
        end
        GS_DELAY: begin
          if (!gate_ok) begin
            state <= GS_IDLE;
          end else if (tick) begin
            dly_cnt <= dly_cnt + 21'd1;
            // One tick more, as the first tick may come right after entry
            if (dly_cnt == dly_tgt) begin
              state <= GS_MON;
            end
          end
        end
        GS_MON: begin
          if (!gate_ok) begin
            state <= GS_IDLE;
          end
        end
        default: state <= GS_IDLE;
      endcase
    end
  end

  // Faults, drop flag and latch; a hardware set beats a software clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flt_act <= '0;
      flt_rec <= '0;
      drop <= 1'b0;
      latched <= 1'b0;
    end else begin
      flt_act <= next_act;
      flt_rec <= (flt_rec & ~clr_flt) | (next_act & ~flt_act);
      if (state == GS_MON && fall) begin
        drop <= 1'b1;
      end else if (clr_drop) begin
        drop <= 1'b0;
      end
      if (mode[MODE_LATCH] && new_flt) begin
        latched <= 1'b1;
      end else if (state == GS_IDLE && flt_act == 6'd0) begin
        latched <= 1'b0;
      end
    end
  end

  // Fault logger: fault byte, then six result bytes, then lock
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      log_busy <= 1'b0;
      log_i <= '0;
      lock <= 1'b0;
      flash_wr <= 1'b0;
      flash_waddr <= '0;
      flash_wdata <= '0;
    end else begin
      flash_wr <= log_busy;
      flash_waddr <= FLASH_LOG_BASE + {7'd0, log_i};
      flash_wdata <= (log_i == 3'd0) ? {2'd0, flt_act} : res[3'(log_i - 3'd1)][9:2];
      if (log_go) begin
        log_busy <= 1'b1;
        log_i <= '0;
      end else if (log_busy) begin
        log_i <= log_i + 3'd1;
        if (log_i == 3'(NCH)) begin
          log_busy <= 1'b0;
          lock <= 1'b1;
        end
      end
    end
  end

  // Reset output timeout, counted once every channel is in range
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rto_cnt <= '0;
      reset_out <= 1'b0;
    end else begin
      if (!all_ok) begin
        rto_cnt <= '0;
      end else if (tick && rst_asrt) begin
        rto_cnt <= rto_cnt + 8'd1;
      end
      reset_out <= boot_done && (mode[MODE_RPOL] ? rst_asrt : !rst_asrt);
    end
  end

  // Open-drain fault outputs, released without the gate
  for (genvar g = 0; g < NCH; g++) begin : g_pin
    localparam logic [5:0] GI = A_GPM0[5:0] + 6'(g);
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        gpio_oe_n[g] <= 1'b1;
        gpio_out[g] <= 1'b0;
      end else begin
        gpio_out[g] <= 1'b0;
        gpio_oe_n[g] <= !(boot_done && gate_cmp && |(flt_act & cfg[GI][5:0]));
      end
    end
  end

  // Checks
  logic [15:0] boot_age;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      boot_age <= '0;
    end else if (!boot_done) begin
      boot_age <= boot_age + 16'd1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_mon_needs_gate: assert property ((state == GS_MON) |-> $past(gate_ok))
    else $error("monitoring without gate");
  a_result_stored: assert property (cmp_valid |-> res[cmp_chan] == $past(adc_result))
    else $error("result not stored");
  a_fault_cause: assert property ((|(flt_act & ~$past(flt_act))) |-> $past(cmp_valid && viol))
    else $error("fault without violation");
  a_margin_quiet: assert property ($past(margin) |-> (flt_rec & ~$past(flt_rec)) == 6'd0)
    else $error("fault recorded in margin mode");
  a_boot_quiet: assert property (!boot_done |-> flt_act == 6'd0 && flt_rec == 6'd0)
    else $error("fault during boot");
  a_boot_refuse: assert property ((acc.valid && !boot_done) |=> rsp.ack && rsp.refused)
    else $error("access taken during boot");
  a_boot_bound: assert property (boot_age < 16'(BOOT_MAX_CYC))
    else $error("boot too long");
  a_reset_low: assert property (!boot_done |=> !reset_out)
    else $error("reset output released during boot");
  a_gpio_hiz: assert property ((!boot_done || !gate_cmp) |=> &gpio_oe_n)
    else $error("pin driven before boot or without gate");
  a_drop_cause: assert property ($rose(drop) |-> $past(state == GS_MON && fall))
    else $error("drop flag set without falling gate");
  a_drop_hold: assert property ((drop && !clr_drop) |=> drop)
    else $error("drop flag lost");
  a_encfg_rsvd: assert property ((enc & ~ENCFG_MASK) == 8'h00)
    else $error("reserved enable bits set");
  a_rst_fault: assert property ((boot_done && !all_ok) |=> reset_out == $past(mode[MODE_RPOL]))
    else $error("reset output not asserted on fault");
endmodule
`default_nettype wire

//--- verification/sbe_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbe_far_model (
  // Clock
  input wire logic ref_clk,
  // Flash
  input wire logic [9:0] flash_raddr,
  output logic [7:0] flash_rdata,
  input wire logic flash_wr,
  input wire logic [9:0] flash_waddr,
  input wire logic [7:0] flash_wdata,
  // Converter
  input wire logic adc_start,
  input wire logic [2:0] adc_chan,
  output logic adc_done,
  output logic [9:0] adc_result,
  // Rail levels and converter latency
  input wire logic [5:0][9:0] rails,
  input wire logic [7:0] adc_lat
);
  logic [7:0] log_mem [0:6];
  int log_cnt = 0;
  int start_cnt = 0;
  logic busy = 1'b0;
  logic [2:0] chan = 3'h0;
  logic [7:0] cnt = 8'h00;
  initial begin
    flash_rdata = 8'h00;
    adc_done = 1'b0;
    adc_result = 10'h000;
  end
  // Enable byte all ones, so only the ENCFG_MASK bits may survive the copy
  always @(posedge ref_clk) begin
    flash_rdata <= (flash_raddr == 10'h273) ? 8'hff : 8'h00;
    if (flash_wr) begin
      log_cnt <= log_cnt + 1;
      if (flash_waddr >= 10'h2c0 && flash_waddr <= 10'h2c6) begin
        log_mem[flash_waddr - 10'h2c0] <= flash_wdata;
      end
    end
  end
  // Result is only valid with done; otherwise it toggles every cycle
  always @(posedge ref_clk) begin
    adc_done <= 1'b0;
    adc_result <= ~adc_result;
    if (adc_start) begin
      busy <= 1'b1;
      chan <= adc_chan;
      cnt <= adc_lat;
      start_cnt <= start_cnt + 1;
    end else if (busy && cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (busy) begin
      busy <= 1'b0;
      adc_done <= 1'b1;
      adc_result <= rails[chan];
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  import sbe_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic gate_cmp = 1'b0;
  logic [1:0] address_select_pin = 2'b10;
  sbe_acc_t acc = '0;
  logic page_cmd = 1'b0;
  logic [1:0] page_sel = 2'b00;
  sbe_rsp_t rsp;
  logic [1:0] bus_addr_code;
  logic [9:0] flash_raddr, flash_waddr, adc_result;
  logic [7:0] flash_rdata, flash_wdata, adc_lat = 8'h04;
  logic flash_wr, adc_start, adc_done, reset_out;
  logic [2:0] adc_chan;
  logic [5:0] gpio_out, gpio_oe_n;
  logic [5:0][9:0] rails = {6{10'h200}};
  int err_total = 0;
  int checked = 0;
  int n;
  logic [7:0] d;
  logic rf;
  always #5 ref_clk = ~ref_clk;
  sbe_supervisor #(.BOOT_MAX_CYC(100), .TICK_CYC(4)) dut (.ref_clk(ref_clk), .reset(reset),
    .gate_cmp(gate_cmp), .address_select_pin(address_select_pin), .bus_addr_code(bus_addr_code),
    .acc(acc), .page_cmd(page_cmd), .page_sel(page_sel), .rsp(rsp), .flash_raddr(flash_raddr),
    .flash_rdata(flash_rdata), .flash_wr(flash_wr), .flash_waddr(flash_waddr),
    .flash_wdata(flash_wdata), .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
    .adc_result(adc_result), .reset_out(reset_out), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
  sbe_far_model far (.ref_clk(ref_clk), .flash_raddr(flash_raddr), .flash_rdata(flash_rdata),
    .flash_wr(flash_wr), .flash_waddr(flash_waddr), .flash_wdata(flash_wdata),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done), .adc_result(adc_result),
    .rails(rails), .adc_lat(adc_lat));
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One access per call, started and ended at a falling edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] wd);
    acc.valid = 1'b1;
    acc.wr = w;
    acc.addr = a;
    acc.wdata = wd;
    @(negedge ref_clk);
    acc = '0;
    d = rsp.rdata;
    rf = rsp.refused;
    `CHK("ack", 1'b1, rsp.ack)
    @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    access(1'b1, a, wd);
    `CHK("write refused", 1'b0, rf)
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    `CHK(nm, e, d)
  endtask
  task automatic set_page(input logic [1:0] p);
    page_sel = p;
    page_cmd = 1'b1;
    @(negedge ref_clk);
    page_cmd = 1'b0;
  endtask
  // Budget well above the longest bounded wait in the sequence
  initial begin
    #300000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    `CHK("rst reset_out", 1'b0, reset_out)
    `CHK("rst gpio_oe_n", 6'h3f, gpio_oe_n)
    reset = 1'b0;
    @(negedge ref_clk);
    address_select_pin = 2'b01;
    n = 0;
    rf = 1'b1;
    while (rf === 1'b1 && n < 100) begin
      `CHK("boot reset_out", 1'b0, reset_out)
      `CHK("boot gpio_oe_n", 6'h3f, gpio_oe_n)
      access(1'b0, A_ENCFG, 8'h00);
      n++;
    end
    `CHK("boot refused first", 1'b1, n > 1)
    `CHK("boot ends", 1'b0, rf)
    `CHK("encfg copied", 8'h15, d)
    `CHK("strap", 2'b10, bus_addr_code)
    rdchk("status por", A_STAT, 8'h00);
    rdchk("ov0 por", A_OV0, 8'h00);
    wr(A_ENCFG, 8'hea);
    rdchk("encfg reserved", A_ENCFG, 8'h00);
    set_page(2'b01);
    access(1'b0, A_ENCFG, 8'h00);
    `CHK("page1 refused", 1'b1, rf)
    set_page(2'b00);
    rdchk("page0 ok", A_ENCFG, 8'h00);
    // Channel 0 over, channel 1 under; each drives its own pin
    rails[0] = 10'h3ff;
    rails[1] = 10'h040;
    wr(A_OV0, 8'h80);
    wr(A_OVEN, 8'h01);
    wr(A_UV0 + 8'h01, 8'h40);
    wr(A_UVEN, 8'h02);
    wr(A_GPM0, 8'h01);
    wr(A_GPM0 + 8'h01, 8'h02);
    wr(A_LOGEN, 8'h01);
    wr(A_RTO, 8'h08);
    wr(A_ENCFG, 8'h01);
    repeat (300) @(negedge ref_clk);
    `CHK("no scan gate low", 0, far.start_cnt)
    gate_cmp = 1'b1;
    repeat (400) @(negedge ref_clk);
    `CHK("no scan in delay", 0, far.start_cnt)
    for (n = 0; n < 2000 && gpio_oe_n !== 6'h3c; n++) @(negedge ref_clk);
    `CHK("gpio faults", 6'h3c, gpio_oe_n)
    `CHK("reset asserted", 1'b0, reset_out)
    rdchk("faults", A_FLT, 8'h03);
    rdchk("res0 hi", 8'h00, 8'hff);
    rdchk("res0 lo", 8'h01, 8'hc0);
    rdchk("res1 hi", 8'h02, 8'h10);
    rdchk("res1 lo", 8'h03, 8'h00);
    for (n = 0; n < 200 && far.log_cnt < 7; n++) @(negedge ref_clk);
    `CHK("log writes", 7, far.log_cnt)
    `CHK("log ch0", 8'hff, far.log_mem[1])
    `CHK("log fault", 1'b1, far.log_mem[0][0])
    rdchk("log lock", A_STAT, 8'h01);
    // Rails in range first, so that leaving margin mode makes fresh faults
    rails = {6{10'h200}};
    repeat (100) @(negedge ref_clk);
    wr(A_FLT, 8'h03);
    wr(A_ENCFG, 8'h05);
    wr(A_MODE, 8'h03);
    rails[0] = 10'h3ff;
    rails[1] = 10'h040;
    adc_lat = 8'h28;
    repeat (600) @(negedge ref_clk);
    rdchk("margin faults", A_FLT, 8'h00);
    wr(A_ENCFG, 8'h01);
    repeat (600) @(negedge ref_clk);
    rdchk("normal faults", A_FLT, 8'h03);
    rdchk("latched", A_STAT, 8'h03);
    `CHK("reset active high", 1'b1, reset_out)
    wr(A_MODE, 8'h01);
    `CHK("log locked", 7, far.log_cnt)
    adc_lat = 8'h04;
    gate_cmp = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK("gate low gpio", 6'h3f, gpio_oe_n)
    rdchk("drop set", A_STAT, 8'h05);
    n = far.start_cnt;
    repeat (100) @(negedge ref_clk);
    `CHK("scan stopped", n, far.start_cnt)
    rdchk("drop held", A_STAT, 8'h05);
    wr(A_STAT, 8'h04);
    rdchk("drop cleared", A_STAT, 8'h01);
    wr(A_ENCFG, 8'h00);
    rdchk("no drop idle", A_STAT, 8'h01);
    // Rails back in range; release waits for the delay, then the timeout
    rails = {6{10'h200}};
    wr(A_ENCFG, 8'h01);
    gate_cmp = 1'b1;
    for (n = 0; n < 1500 && reset_out !== 1'b1; n++) @(negedge ref_clk);
    `CHK("reset released", 1'b1, reset_out)
    `CHK("reset held min", 1'b1, n >= 480)
    wr(A_ENCFG, 8'h00);
    rdchk("drop sw edge", A_STAT, 8'h05);
    // Second power-on in mid-run: flags and lock must come back cleared
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    n = 0;
    rf = 1'b1;
    while (rf === 1'b1 && n < 100) begin
      access(1'b0, A_STAT, 8'h00);
      n++;
    end
    `CHK("por status", 8'h00, d)
    rdchk("por ov0", A_OV0, 8'h00);
    `CHK("por strap", 2'b01, bus_addr_code)
    report_and_stop();
  end
endmodule
`undef CHK
`default_nettype wire
